// >>> logic/acfl_defines.svh
// Offsets, field positions, reset values and sizes of the cell field and link block.
// Operation
// - Hold a programmable eight-bit overlay value for RM cell switch parameters.
// - Overlay ingress backward RM cells only with backward and global enables set.
// - Overlay ingress forward RM cells only with forward and global enables set.
// - Overlay location picks one of twelve ingress switch-parameter bytes.
// - Only bits whose mask bit is one take the overlay value.
// - Egress non-RM cell with PTI bit 2 clear loses PTI bit 1 when flagged.
// - Transparent ingress connection copies header CLP into the overhead CLP bit.
// - Transparent ingress cell gets the configured substitute value in header CLP.
// - Egress restores header CLP from overhead CLP when restore is enabled.
// - Selective discard acts only while the global congestion discard bit is set.
// - Per-connection field enables discard for CLP one cells or all cells.
// - Up to sixteen links, total bandwidth within the cell-processing rate.
// - Per-link ingress and egress counters by class and CLP, plus inactive count.
// - Received link number indexes sixteen per-link compression registers.
// - Transmit link bus carries current or next cell link per timing select.
// - Egress cell transfer starts only after the addressed PHY acknowledges.
// - Egress destination link comes from context memory with the new header.
// - Extraction copies carry PHY link on ingress, context link on egress.
`ifndef ACFL_DEFINES_SVH
`define ACFL_DEFINES_SVH

`define ACFL_ADDR_W 8
`define ACFL_LINK_W 4
`define ACFL_NUM_LINKS 16
`define ACFL_PARAM_BYTES 12
`define ACFL_CNT_W 16
`define ACFL_NUM_CNT 128

`define ACFL_OFS_GENERAL_CONFIG 8'h00
`define ACFL_OFS_OVERLAY 8'h04
`define ACFL_OFS_INGRESS_PHY_CONFIG 8'h08
`define ACFL_OFS_EGRESS_PHY_CONFIG 8'h0C
`define ACFL_OFS_COUNTER_SELECT 8'h10
`define ACFL_OFS_COUNTER_VALUE 8'h14
`define ACFL_OFS_INACTIVE_COUNT 8'h18
`define ACFL_OFS_EGRESS_STATUS 8'h1C
`define ACFL_OFS_LINK_BASE 8'h40

`define ACFL_GC_LINK_TIMING 0
`define ACFL_GC_CONG_DISCARD 1
`define ACFL_GC_GLOBAL_RM_OVL 2
`define ACFL_GC_BACKWARD_RM_OVL 3
`define ACFL_GC_FORWARD_RM_OVL 4
`define ACFL_GC_CLP_RESTORE 5
`define ACFL_GC_W 6

`define ACFL_OVL_VALUE_LSB 0
`define ACFL_OVL_MASK_LSB 8
`define ACFL_OVL_LOC_LSB 16
`define ACFL_PHY_CELL_MODE 0
`define ACFL_LINK_CFG_W 16

`define ACFL_RST_GENERAL_CONFIG 6'h00
`define ACFL_RST_OVERLAY 20'h0_0000
`define ACFL_RST_LINK_CFG 16'h0000

`define ACFL_DISCARD_OFF 2'h0
`define ACFL_DISCARD_CLP1 2'h1
`define ACFL_DISCARD_ALL 2'h2

`define ACFL_ACCEPT_SETTLE 2'h2

`endif

// >>> logic/acfl_pkg.sv
// Types shared by the cell field and link block and its users.
package acfl_pkg;

  typedef struct packed {
    logic valid;
    logic is_brm;
    logic is_frm;
    logic is_oam;
    logic active;
    logic hdr_clp;
    logic clp_transparent_en;
    logic clp_sub_value;
    logic [1:0] marking_discard;
    logic copy_to_extract;
    logic [11:0][7:0] sw_params;
  } acfl_ing_cell_t;

  typedef struct packed {
    logic valid;
    logic discard;
    logic hdr_clp;
    logic overhead_clp;
    logic [3:0] link;
    logic [15:0] compression_cfg;
    logic [11:0][7:0] sw_params;
  } acfl_ing_out_t;

  typedef struct packed {
    logic valid;
    logic is_rm;
    logic is_oam;
    logic [2:0] pti;
    logic hdr_clp;
    logic overhead_clp;
    logic efci_clear_flag;
    logic copy_to_extract;
    logic [3:0] link;
    logic [27:0] new_hdr_addr;
  } acfl_egr_cell_t;

  typedef struct packed {
    logic is_oam;
    logic [2:0] pti;
    logic hdr_clp;
    logic [3:0] link;
    logic [27:0] new_hdr_addr;
  } acfl_egr_out_t;

  typedef struct packed {
    logic valid;
    logic from_egress;
    logic [3:0] link;
  } acfl_ext_tag_t;

  typedef enum logic [2:0] {
    EG_IDLE = 3'b001,
    EG_WAIT = 3'b010,
    EG_SEND = 3'b100
  } acfl_eg_state_t;

endpackage : acfl_pkg

// >>> logic/acfl_cell_field_link.sv
// Cell header and overhead modification with multi-link handling and registers.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acfl_defines.svh"

module acfl_cell_field_link (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [`ACFL_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Ingress cell stream and link pins
  input wire logic [`ACFL_LINK_W-1:0] rx_link_number_bus,
  input wire acfl_pkg::acfl_ing_cell_t ing_cell,
  output acfl_pkg::acfl_ing_out_t ing_out,
  // Egress cell stream from context lookup
  input wire acfl_pkg::acfl_egr_cell_t egr_cell,
  output logic egr_ready,
  // Egress PHY side
  input wire logic tx_phy_accept,
  output logic [`ACFL_LINK_W-1:0] tx_link_number_bus,
  output logic tx_cell_valid,
  output acfl_pkg::acfl_egr_out_t tx_cell,
  // Extraction queue tags
  output acfl_pkg::acfl_ext_tag_t ing_ext_tag,
  output acfl_pkg::acfl_ext_tag_t egr_ext_tag,
  // PHY operation mode
  output logic ingress_phy_cell_mode,
  output logic egress_phy_cell_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [7:0] overlay_byte(
    input logic [7:0] orig,
    input logic [7:0] value,
    input logic [7:0] mask
  );
    overlay_byte = (orig & ~mask) | (value & mask);
  endfunction : overlay_byte

  function automatic logic [6:0] cnt_index(
    input logic from_egress,
    input logic is_oam,
    input logic clp,
    input logic [`ACFL_LINK_W-1:0] link
  );
    cnt_index = {from_egress, is_oam, clp, link};
  endfunction : cnt_index

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [`ACFL_GC_W-1:0] general_config;
  logic [19:0] overlay_reg;
  logic ingress_phy_config;
  logic egress_phy_config;
  logic [6:0] counter_select;
  logic [`ACFL_LINK_CFG_W-1:0] per_link_compression_regs [`ACFL_NUM_LINKS];
  logic [`ACFL_CNT_W-1:0] link_cnt [`ACFL_NUM_CNT];
  logic [`ACFL_CNT_W-1:0] inactive_cnt;

  wire link_number_timing_select = general_config[`ACFL_GC_LINK_TIMING];
  wire global_congestion_discard_enable = general_config[`ACFL_GC_CONG_DISCARD];
  wire global_rm_overlay_enable = general_config[`ACFL_GC_GLOBAL_RM_OVL];
  wire backward_rm_overlay_enable = general_config[`ACFL_GC_BACKWARD_RM_OVL];
  wire forward_rm_overlay_enable = general_config[`ACFL_GC_FORWARD_RM_OVL];
  wire egress_clp_restore_enable = general_config[`ACFL_GC_CLP_RESTORE];
  wire [7:0] overlay_value = overlay_reg[`ACFL_OVL_VALUE_LSB +: 8];
  wire [7:0] overlay_mask = overlay_reg[`ACFL_OVL_MASK_LSB +: 8];
  wire [3:0] overlay_byte_location = overlay_reg[`ACFL_OVL_LOC_LSB +: 4];

  // Cell mode is a software duty when several links attach; the bits only steer the PHY side.
  assign ingress_phy_cell_mode = ingress_phy_config;
  assign egress_phy_cell_mode = egress_phy_config;

  wire is_link_addr = reg_addr[7:6] == 2'(`ACFL_OFS_LINK_BASE >> 6);
  wire [3:0] link_addr_index = reg_addr[5:2];
  wire wr_gc = reg_wr && reg_addr == `ACFL_OFS_GENERAL_CONFIG;
  wire wr_ovl = reg_wr && reg_addr == `ACFL_OFS_OVERLAY;
  wire wr_iphy = reg_wr && reg_addr == `ACFL_OFS_INGRESS_PHY_CONFIG;
  wire wr_ephy = reg_wr && reg_addr == `ACFL_OFS_EGRESS_PHY_CONFIG;
  wire wr_sel = reg_wr && reg_addr == `ACFL_OFS_COUNTER_SELECT;
  wire wr_link = reg_wr && is_link_addr && reg_addr[1:0] == 2'b00;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      general_config <= `ACFL_RST_GENERAL_CONFIG;
      overlay_reg <= `ACFL_RST_OVERLAY;
      ingress_phy_config <= 1'b0;
      egress_phy_config <= 1'b0;
      counter_select <= 7'h00;
    end
    else
    begin
      if (wr_gc)
        general_config <= reg_wdata[`ACFL_GC_W-1:0];
      if (wr_ovl)
        overlay_reg <= reg_wdata[19:0];
      if (wr_iphy)
        ingress_phy_config <= reg_wdata[`ACFL_PHY_CELL_MODE];
      if (wr_ephy)
        egress_phy_config <= reg_wdata[`ACFL_PHY_CELL_MODE];
      if (wr_sel)
        counter_select <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < `ACFL_NUM_LINKS; i++)
    begin
      if (!rst_b)
        per_link_compression_regs[i] <= `ACFL_RST_LINK_CFG;
      else if (wr_link && link_addr_index == 4'(i))
        per_link_compression_regs[i] <= reg_wdata[`ACFL_LINK_CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link pin synchroniser

  // The PHY drives its number for the whole cell, so two stages settle long before use.
  logic [`ACFL_LINK_W-1:0] rx_link_sync1;
  logic [`ACFL_LINK_W-1:0] rx_link;
  logic accept_sync1;
  logic accept_s;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_link_sync1 <= 4'h0;
      rx_link <= 4'h0;
      accept_sync1 <= 1'b0;
      accept_s <= 1'b0;
    end
    else
    begin
      rx_link_sync1 <= rx_link_number_bus;
      rx_link <= rx_link_sync1;
      accept_sync1 <= tx_phy_accept;
      accept_s <= accept_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ingress cell modification

  wire ovl_brm = ing_cell.is_brm && backward_rm_overlay_enable && global_rm_overlay_enable;
  wire ovl_frm = ing_cell.is_frm && forward_rm_overlay_enable && global_rm_overlay_enable;
  wire ovl_apply = ovl_brm || ovl_frm;
  logic [11:0][7:0] ing_params_mod;

  always_comb
  begin
    ing_params_mod = ing_cell.sw_params;
    for (int b = 0; b < `ACFL_PARAM_BYTES; b++)
    begin
      if (ovl_apply && overlay_byte_location == 4'(b))
        ing_params_mod[b] = overlay_byte(ing_cell.sw_params[b], overlay_value, overlay_mask);
    end
  end

  wire ing_hdr_clp = ing_cell.clp_transparent_en ? ing_cell.clp_sub_value : ing_cell.hdr_clp;
  wire ing_ovh_clp = ing_cell.clp_transparent_en ? ing_cell.hdr_clp : 1'b0;
  wire discard_sel_clp1 = ing_cell.marking_discard == `ACFL_DISCARD_CLP1 && ing_cell.hdr_clp;
  wire discard_sel_all = ing_cell.marking_discard == `ACFL_DISCARD_ALL;
  wire ing_discard = global_congestion_discard_enable && (discard_sel_clp1 || discard_sel_all);
  wire [`ACFL_LINK_CFG_W-1:0] ing_comp_cfg = per_link_compression_regs[rx_link];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ing_out <= '0;
      ing_ext_tag <= '0;
    end
    else
    begin
      ing_out.valid <= ing_cell.valid;
      ing_out.discard <= ing_cell.valid && ing_discard;
      ing_out.hdr_clp <= ing_hdr_clp;
      ing_out.overhead_clp <= ing_ovh_clp;
      ing_out.link <= rx_link;
      ing_out.compression_cfg <= ing_comp_cfg;
      ing_out.sw_params <= ing_params_mod;
      ing_ext_tag.valid <= ing_cell.valid && ing_cell.copy_to_extract;
      ing_ext_tag.from_egress <= 1'b0;
      ing_ext_tag.link <= rx_link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Egress cell modification and holding slots

  // One pending slot and one slot in transfer: enough to announce the next link early.
  acfl_pkg::acfl_eg_state_t eg_state;
  acfl_pkg::acfl_eg_state_t next_eg_state;
  logic next_full;
  acfl_pkg::acfl_egr_out_t next_cell;
  acfl_pkg::acfl_egr_out_t cur_cell;

  assign egr_ready = !next_full;
  wire egr_take = egr_cell.valid && egr_ready;
  wire load_cur = eg_state == acfl_pkg::EG_IDLE && next_full;
  wire clear_efci = !egr_cell.is_rm && !egr_cell.pti[2] && egr_cell.efci_clear_flag;

  logic [2:0] egr_pti_mod;
  logic egr_clp_mod;
  always_comb
  begin
    egr_pti_mod = egr_cell.pti;
    if (clear_efci)
      egr_pti_mod[1] = 1'b0;
    egr_clp_mod = egress_clp_restore_enable ? egr_cell.overhead_clp : egr_cell.hdr_clp;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      next_full <= 1'b0;
      next_cell <= '0;
      egr_ext_tag <= '0;
    end
    else
    begin
      if (egr_take)
      begin
        next_full <= 1'b1;
        next_cell.is_oam <= egr_cell.is_oam;
        next_cell.pti <= egr_pti_mod;
        next_cell.hdr_clp <= egr_clp_mod;
        next_cell.link <= egr_cell.link;
        next_cell.new_hdr_addr <= egr_cell.new_hdr_addr;
      end
      else if (load_cur)
        next_full <= 1'b0;
      egr_ext_tag.valid <= egr_take && egr_cell.copy_to_extract;
      egr_ext_tag.from_egress <= 1'b1;
      egr_ext_tag.link <= egr_cell.link;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Egress transfer state machine

  // The acknowledge reaches accept_s two cycles late, so right after a cell it is stale.
  logic [1:0] accept_settle;
  wire accept_fresh = accept_settle == 2'h0;

  always_comb
  begin
    case (eg_state)
      acfl_pkg::EG_IDLE: next_eg_state = next_full ? acfl_pkg::EG_WAIT : acfl_pkg::EG_IDLE;
      acfl_pkg::EG_WAIT:
        next_eg_state = accept_s && accept_fresh ? acfl_pkg::EG_SEND : acfl_pkg::EG_WAIT;
      acfl_pkg::EG_SEND: next_eg_state = acfl_pkg::EG_IDLE;
      default: next_eg_state = acfl_pkg::EG_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      eg_state <= acfl_pkg::EG_IDLE;
      cur_cell <= '0;
      accept_settle <= 2'h0;
    end
    else
    begin
      eg_state <= next_eg_state;
      if (tx_cell_valid)
        accept_settle <= `ACFL_ACCEPT_SETTLE;
      else if (!accept_fresh)
        accept_settle <= accept_settle - 2'h1;
      if (load_cur)
        cur_cell <= next_cell;
    end
  end

  assign tx_cell_valid = eg_state == acfl_pkg::EG_SEND;
  assign tx_cell = cur_cell;
  // With the timing select set the bus looks one cell ahead, letting the PHY prepare.
  assign tx_link_number_bus = link_number_timing_select ? next_cell.link : cur_cell.link;

  ////////////////////////////////////////////////////////////////////////////
  // Per-link and inactive counters

  // Ingress and egress never share an index, so both can count in the same cycle.
  wire ing_count = ing_out.valid;
  logic ing_cnt_oam;
  logic ing_cnt_clp;
  logic ing_cnt_active;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ing_cnt_oam <= 1'b0;
      ing_cnt_clp <= 1'b0;
      ing_cnt_active <= 1'b0;
    end
    else
    begin
      ing_cnt_oam <= ing_cell.is_oam;
      ing_cnt_clp <= ing_cell.hdr_clp;
      ing_cnt_active <= ing_cell.active;
    end
  end

  wire [6:0] ing_idx = cnt_index(1'b0, ing_cnt_oam, ing_cnt_clp, ing_out.link);
  wire [6:0] egr_idx = cnt_index(1'b1, cur_cell.is_oam, cur_cell.hdr_clp, cur_cell.link);
  wire ing_inc = ing_count && ing_cnt_active;
  wire inact_inc = ing_count && !ing_cnt_active;

  always_ff @(posedge clk)
  begin
    for (int c = 0; c < `ACFL_NUM_CNT; c++)
    begin
      if (!rst_b)
        link_cnt[c] <= '0;
      else if ((ing_inc && ing_idx == 7'(c)) || (tx_cell_valid && egr_idx == 7'(c)))
        link_cnt[c] <= link_cnt[c] + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      inactive_cnt <= '0;
    else if (inact_inc)
      inactive_cnt <= inactive_cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (is_link_addr)
      next_rdata = {16'h0000, per_link_compression_regs[link_addr_index]};
    else
    begin
      case (reg_addr)
        `ACFL_OFS_GENERAL_CONFIG: next_rdata = {26'h000_0000, general_config};
        `ACFL_OFS_OVERLAY: next_rdata = {12'h000, overlay_reg};
        `ACFL_OFS_INGRESS_PHY_CONFIG: next_rdata = {31'h0000_0000, ingress_phy_config};
        `ACFL_OFS_EGRESS_PHY_CONFIG: next_rdata = {31'h0000_0000, egress_phy_config};
        `ACFL_OFS_COUNTER_SELECT: next_rdata = {25'h000_0000, counter_select};
        `ACFL_OFS_COUNTER_VALUE: next_rdata = {16'h0000, link_cnt[counter_select]};
        `ACFL_OFS_INACTIVE_COUNT: next_rdata = {16'h0000, inactive_cnt};
        `ACFL_OFS_EGRESS_STATUS:
          next_rdata = {20'h0_0000, cur_cell.link, next_cell.link, next_full, eg_state};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule : acfl_cell_field_link
`default_nettype wire

// >>> tb/acfl_phy_model.sv
// Behavioural model of the attached PHY devices: receive link pins and transmit acknowledge.
`timescale 1ns/1ps
`default_nettype none

module acfl_phy_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench controls
  input wire logic rx_active,
  input wire logic [3:0] rx_link,
  input wire logic slow,
  // Device pins
  input wire logic tx_cell_valid,
  output logic [3:0] rx_link_number_bus,
  output logic tx_phy_accept
);
  logic [3:0] last_link;
  logic [3:0] hold;

  // An idle link bus shows the inverse of its last number, so a stale value never looks valid.
  assign rx_link_number_bus = rx_active ? rx_link : ~last_link;
  // A slow PHY refuses further cells for a while after each one it takes.
  assign tx_phy_accept = (hold == 4'h0);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      last_link <= 4'h0;
      hold <= 4'h0;
    end
    else
    begin
      if (rx_active)
        last_link <= rx_link;
      if (tx_cell_valid && slow)
        hold <= 4'h8;
      else if (hold != 4'h0)
        hold <= hold - 4'h1;
    end
  end
endmodule : acfl_phy_model

`default_nettype wire

// >>> tb/acfl_cell_field_link_assertions.sv
// Port-level checks of the cell field and link block.
`timescale 1ns/1ps
`default_nettype none

module acfl_cfl_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Cell streams
  input wire acfl_pkg::acfl_ing_cell_t ing_cell,
  input wire acfl_pkg::acfl_ing_out_t ing_out,
  input wire acfl_pkg::acfl_egr_cell_t egr_cell,
  input wire logic egr_ready,
  // PHY side and tags
  input wire logic tx_phy_accept,
  input wire logic tx_cell_valid,
  input wire acfl_pkg::acfl_ext_tag_t ing_ext_tag,
  input wire acfl_pkg::acfl_ext_tag_t egr_ext_tag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire take = egr_cell.valid && egr_ready;

  a_plain_params:
  assert property (ing_cell.valid && !ing_cell.is_brm && !ing_cell.is_frm |=>
    ing_out.valid && ing_out.sw_params == $past(ing_cell.sw_params))
    else $error("non-RM switch parameters altered");
  a_clp_moved:
  assert property (ing_cell.valid && ing_cell.clp_transparent_en |=>
    ing_out.overhead_clp == $past(ing_cell.hdr_clp) &&
    ing_out.hdr_clp == $past(ing_cell.clp_sub_value))
    else $error("transparent loss priority not moved");
  a_clp_kept:
  assert property (ing_cell.valid && !ing_cell.clp_transparent_en |=>
    !ing_out.overhead_clp && ing_out.hdr_clp == $past(ing_cell.hdr_clp))
    else $error("opaque loss priority changed");
  a_discard_off:
  assert property (ing_cell.valid && ing_cell.marking_discard != 2'h2 &&
    !(ing_cell.marking_discard == 2'h1 && ing_cell.hdr_clp) |=> !ing_out.discard)
    else $error("discard on an unmarked cell");
  a_send_after_ack:
  assert property (tx_cell_valid |-> $past(tx_phy_accept, 3))
    else $error("cell sent without acknowledge");
  a_single_pulse:
  assert property (tx_cell_valid |=> !tx_cell_valid [*3])
    else $error("transmit pulse too long");
  a_egr_tag:
  assert property (take && egr_cell.copy_to_extract |=> egr_ext_tag.valid &&
    egr_ext_tag.from_egress && egr_ext_tag.link == $past(egr_cell.link))
    else $error("egress extraction tag wrong");
  a_ing_tag:
  assert property (ing_cell.valid && ing_cell.copy_to_extract |=> ing_ext_tag.valid &&
    !ing_ext_tag.from_egress && ing_ext_tag.link == ing_out.link)
    else $error("ingress extraction tag wrong");
endmodule : acfl_cfl_checker

bind acfl_cell_field_link acfl_cfl_checker acfl_cfl_checker_inst (
  .clk, .rst_b, .ing_cell, .ing_out, .egr_cell, .egr_ready, .tx_phy_accept,
  .tx_cell_valid, .ing_ext_tag, .egr_ext_tag);

`default_nettype wire

// >>> tb/acfl_cell_field_link_test.sv
// Self-checking bench for the cell field and link block.
`timescale 1ns/1ps
`default_nettype none

module acfl_cell_field_link_test;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  acfl_pkg::acfl_ing_cell_t ing_cell = '0;
  acfl_pkg::acfl_ing_out_t ing_out;
  acfl_pkg::acfl_egr_cell_t egr_cell = '0;
  acfl_pkg::acfl_egr_out_t tx_cell;
  acfl_pkg::acfl_ext_tag_t ing_ext_tag;
  acfl_pkg::acfl_ext_tag_t egr_ext_tag;
  logic [3:0] rx_link_number_bus;
  logic [3:0] tx_link_number_bus;
  logic [3:0] rx_link = 4'h0;
  logic rx_active = 1'h0;
  logic slow = 1'h0;
  logic egr_ready;
  logic tx_phy_accept;
  logic tx_cell_valid;
  logic ingress_phy_cell_mode;
  logic egress_phy_cell_mode;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] d;
  acfl_pkg::acfl_ing_cell_t c;
  acfl_pkg::acfl_egr_cell_t e;

  acfl_cell_field_link acfl_cell_field_link_inst (.clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_link_number_bus, .ing_cell, .ing_out, .egr_cell,
    .egr_ready, .tx_phy_accept, .tx_link_number_bus, .tx_cell_valid, .tx_cell,
    .ing_ext_tag, .egr_ext_tag, .ingress_phy_cell_mode, .egress_phy_cell_mode);
  acfl_phy_model acfl_phy_model_inst (.clk, .rst_b, .rx_active, .rx_link, .slow,
    .tx_cell_valid, .rx_link_number_bus, .tx_phy_accept);

  always #50 clk = ~clk;

  // The ceiling sits well above the few hundred cycles the scenarios need.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk)
    begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
    end
    @(posedge clk) reg_wr <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk)
    begin
      reg_addr <= a;
      reg_rd <= 1'h1;
    end
    @(posedge clk) reg_rd <= 1'h0;
    @(negedge clk) q = reg_rdata;
  endtask : rd

  task ing(input acfl_pkg::acfl_ing_cell_t x);
    @(posedge clk) ing_cell <= x;
    @(posedge clk) ing_cell.valid <= 1'h0;
    @(negedge clk);
  endtask : ing

  task cell_init;
    c = '0;
    c.valid = 1'h1;
    c.active = 1'h1;
  endtask : cell_init

  task egr_put(input acfl_pkg::acfl_egr_cell_t x);
    @(posedge clk) egr_cell <= x;
    @(negedge clk);
    while (egr_ready !== 1'h1) @(negedge clk);
    @(posedge clk) egr_cell.valid <= 1'h0;
  endtask : egr_put

  task tx_wait;
    n = 0;
    @(negedge clk);
    while (tx_cell_valid !== 1'h1)
    begin
      n++;
      @(negedge clk);
    end
  endtask : tx_wait

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(8'h00, d);
    chk(d, 32'h0);
    wr(8'h04, 32'h000F_5AA5);
    rd(8'h04, d);
    chk(d, 32'h000F_5AA5);
    rd(8'h24, d);
    chk(d, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h1);
    @(negedge clk);
    chk({ingress_phy_cell_mode, egress_phy_cell_mode}, 2'h3);
  endtask : t_regs

  task t_links;
    wr(8'h5C, 32'h0000_1234);
    rx_link <= 4'h7;
    rx_active <= 1'h1;
    repeat (3) @(posedge clk);
    cell_init();
    c.copy_to_extract = 1'h1;
    ing(c);
    chk({ing_out.link, ing_out.compression_cfg}, 20'h7_1234);
    chk(ing_ext_tag, 6'h27);
    c.active = 1'h0;
    ing(c);
    c.active = 1'h1;
    c.is_oam = 1'h1;
    c.hdr_clp = 1'h1;
    ing(c);
    rx_active <= 1'h0;
    wr(8'h10, 32'h7);
    rd(8'h14, d);
    chk(d, 32'h1);
    wr(8'h10, 32'h37);
    rd(8'h14, d);
    chk(d, 32'h1);
    rd(8'h18, d);
    chk(d, 32'h1);
  endtask : t_links

  task t_overlay;
    wr(8'h04, 32'h0009_78CD);
    wr(8'h00, 32'h0C);
    cell_init();
    c.sw_params = {12{8'hFF}};
    c.is_brm = 1'h1;
    ing(c);
    chk({ing_out.sw_params[9], ing_out.sw_params[8]}, 16'hCFFF);
    c.is_brm = 1'h0;
    c.is_frm = 1'h1;
    ing(c);
    chk(ing_out.sw_params[9], 8'hFF);
    wr(8'h00, 32'h14);
    ing(c);
    chk(ing_out.sw_params[9], 8'hCF);
    wr(8'h00, 32'h18);
    c.is_frm = 1'h0;
    c.is_brm = 1'h1;
    ing(c);
    chk(ing_out.sw_params[9], 8'hFF);
  endtask : t_overlay

  task t_clp;
    cell_init();
    c.clp_transparent_en = 1'h1;
    c.hdr_clp = 1'h1;
    ing(c);
    chk({ing_out.hdr_clp, ing_out.overhead_clp}, 2'h1);
    c.hdr_clp = 1'h0;
    c.clp_sub_value = 1'h1;
    ing(c);
    chk({ing_out.hdr_clp, ing_out.overhead_clp}, 2'h2);
    c.clp_transparent_en = 1'h0;
    c.hdr_clp = 1'h1;
    c.clp_sub_value = 1'h0;
    ing(c);
    chk({ing_out.hdr_clp, ing_out.overhead_clp}, 2'h2);
  endtask : t_clp

  task t_discard;
    cell_init();
    for (int g = 0; g < 2; g++)
    begin
      wr(8'h00, g << 1);
      for (int i = 0; i < 8; i++)
      begin
        c.marking_discard = i[2:1];
        c.hdr_clp = i[0];
        ing(c);
        chk(ing_out.discard, g[0] && (i[2:1] == 2 || (i[2:1] == 1 && i[0])));
      end
    end
  endtask : t_discard

  task eg_one(input logic [2:0] p, input logic rm, input logic [3:0] lk, input logic [3:0] ex);
    e = '0;
    e.valid = 1'h1;
    e.is_rm = rm;
    e.pti = p;
    e.overhead_clp = 1'h1;
    e.efci_clear_flag = 1'h1;
    e.copy_to_extract = 1'h1;
    e.link = lk;
    e.new_hdr_addr = 28'h123_4567;
    egr_put(e);
    @(negedge clk);
    chk(egr_ext_tag, {2'h3, lk});
    tx_wait();
    chk({tx_cell.pti, tx_cell.hdr_clp}, ex);
    chk({tx_cell.link, tx_cell.new_hdr_addr}, {lk, 28'h123_4567});
    chk(tx_link_number_bus, lk);
  endtask : eg_one

  task t_egress;
    wr(8'h00, 32'h20);
    eg_one(3'h2, 1'h0, 4'h5, 4'h1);
    eg_one(3'h2, 1'h1, 4'hA, 4'h5);
    eg_one(3'h6, 1'h0, 4'h3, 4'hD);
    wr(8'h00, 32'h0);
    eg_one(3'h0, 1'h0, 4'hF, 4'h0);
    wr(8'h10, 32'h55);
    rd(8'h14, d);
    chk(d, 32'h1);
  endtask : t_egress

  // Three cells back to back against a slow PHY: the middle one must wait for acknowledge.
  task t_link_timing;
    wr(8'h00, 32'h1);
    slow <= 1'h1;
    e = '0;
    e.valid = 1'h1;
    e.link = 4'h2;
    egr_put(e);
    e.link = 4'h6;
    egr_put(e);
    e.link = 4'h9;
    egr_put(e);
    tx_wait();
    chk(n >= 6, 1'h1);
    chk({tx_cell.link, tx_link_number_bus}, 8'h69);
    tx_wait();
    chk(tx_cell.link, 4'h9);
    slow <= 1'h0;
  endtask : t_link_timing

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    t_regs();
    t_links();
    t_overlay();
    t_clp();
    t_discard();
    t_egress();
    t_link_timing();
    end_of_test();
  end
endmodule : acfl_cell_field_link_test

`default_nettype wire
